// [src/phase_zone_config_control.sv]
// Phase configuration, strap decode and power zone selection
`timescale 1ns/1ps
`include "pzc_cfg.svh"
module phase_zone_config_control #(
	parameter int SAMPLE_CYCLES = `PZC_SAMPLE_CYCLES
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// Pins, asynchronous to the clock
	input  wire logic               enable,
	input  wire logic               powerSavingHigh,
	input  wire logic               powerSavingLow,
	input  wire logic               outputRegulated,
	input  wire logic               rampSupplyLow,
	input  wire logic [7:0]         phaseSensePositive,
	// Strap measurement results, same clock
	input  wire logic               strapDone,
	input  wire logic [2:0]         fixedZoneStrapFirst,
	input  wire logic [2:0]         fixedZoneStrapSecond,
	input  wire pzc_pkg::pzc_byte_t shedThresholdStrap1,
	input  wire pzc_pkg::pzc_byte_t shedThresholdStrap2,
	input  wire pzc_pkg::pzc_byte_t shedThresholdStrap3,
	input  wire pzc_pkg::pzc_byte_t shedThresholdStrap4,
	input  wire logic [2:0]         loadlineAddressStrap,
	// Total current code, same clock
	input  wire pzc_pkg::pzc_byte_t totalCurrentLevel,
	// Register side of the serial slave
	input  wire logic               regWrite,
	input  wire pzc_pkg::pzc_byte_t regAddr,
	input  wire pzc_pkg::pzc_byte_t regWriteData,
	output pzc_pkg::pzc_byte_t      regReadData,
	// Control outputs
	output pzc_pkg::pzc_byte_t      phaseDriveOut,
	output pzc_pkg::pzc_byte_t      activePhases,
	output pzc_pkg::pzc_zone_t      powerZone,
	output logic                    continuousConduction,
	output logic                    discontinuousConduction,
	output logic                    undervoltageLockout,
	output pzc_pkg::pzc_byte_t      loadlinePercent,
	output pzc_pkg::pzc_byte_t      slaveAddress,
	output logic                    strapsLatched
);
	import pzc_pkg::*;

	localparam int SYNC_W = 13;

	logic [SYNC_W-1:0] syncFirst;
	logic [SYNC_W-1:0] syncSecond;
	logic              enableSync;
	logic              psiHighSync;
	logic              psiLowSync;
	logic              regulatedSync;
	logic              rampLowSync;
	logic [7:0]        senseSync;
	logic              enablePrev;
	logic              enableRise;
	logic [1:0]        psiLive;
	logic [1:0]        psiHeld;
	logic [1:0]        psiUsed;
	logic              regulatedSeen;
	logic              lowUseFirst;
	logic [3:0]        phaseCount;
	pzc_zone_t         strapFirst;
	pzc_zone_t         strapSecond;
	pzc_byte_t         fixedZoneSelect;
	pzc_byte_t         thresh [4];
	pzc_byte_t         loadlineReg;
	pzc_mode_e         mode;
	pzc_mode_e         next_mode;
	logic [10:0]       sampleCount;
	logic              sampleTick;
	pzc_zone_t         shedZone;
	pzc_zone_t         next_shedZone;
	pzc_zone_t         fixedRaw;
	pzc_zone_t         rawZone;
	pzc_zone_t         mappedZone;
	pzc_byte_t         zoneMask;

	// Level codes for the three-level power-saving input
	localparam logic [1:0] PSI_LOW  = 2'd0;
	localparam logic [1:0] PSI_MID  = 2'd1;
	localparam logic [1:0] PSI_HIGH = 2'd2;

	// Keep only the run of enabled phases that starts at phase one
	function automatic pzc_byte_t contiguousMask(input pzc_byte_t sense);
		logic keep;
		contiguousMask = 8'h00;
		keep = 1'b1;
		for (int i = 0; i < `PZC_PHASES; i++) begin
			keep = keep & ~sense[i];
			contiguousMask[i] = keep;
		end
	endfunction

	// Number of set bits in a phase mask
	function automatic logic [3:0] countPhases(input pzc_byte_t mask);
		countPhases = 4'd0;
		for (int i = 0; i < `PZC_PHASES; i++) begin
			countPhases = countPhases + {3'd0, mask[i]};
		end
	endfunction

	// Zone strap index, anything past the last resistor reads as zone 4
	function automatic pzc_zone_t clampZone(input logic [2:0] code);
		clampZone = (code > `PZC_ZONE_MAX) ? `PZC_ZONE_MAX : code;
	endfunction

	// Two flip-flops on every pin input
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			syncFirst  <= '0;
			syncSecond <= '0;
		end else begin
			syncFirst  <= {enable, powerSavingHigh, powerSavingLow,
				outputRegulated, rampSupplyLow, phaseSensePositive};
			syncSecond <= syncFirst;
		end
	end

	assign enableSync    = syncSecond[12];
	assign psiHighSync   = syncSecond[11];
	assign psiLowSync    = syncSecond[10];
	assign regulatedSync = syncSecond[9];
	assign rampLowSync   = syncSecond[8];
	assign senseSync     = syncSecond[7:0];

	// Decode the power-saving comparators into a level
	always_comb begin
		if (psiHighSync) begin
			psiLive = PSI_HIGH;
		end else if (psiLowSync) begin
			psiLive = PSI_LOW;
		end else begin
			psiLive = PSI_MID;
		end
	end

	// Strap results caught once, on the first measurement done
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			strapsLatched <= 1'b0;
			activePhases  <= 8'hFF;
			strapFirst    <= 3'd0;
			strapSecond   <= 3'd0;
			slaveAddress  <= `PZC_ADDR_PAIR0;
		end else if (strapDone && !strapsLatched) begin
			strapsLatched <= 1'b1;
			activePhases  <= contiguousMask(senseSync);
			strapFirst    <= clampZone(fixedZoneStrapFirst);
			strapSecond   <= clampZone(fixedZoneStrapSecond);
			unique case (loadlineAddressStrap[2:1])
				2'd0: slaveAddress <= `PZC_ADDR_PAIR0;
				2'd1: slaveAddress <= `PZC_ADDR_PAIR1;
				2'd2: slaveAddress <= `PZC_ADDR_PAIR2;
				2'd3: slaveAddress <= `PZC_ADDR_PAIR3;
			endcase
		end
	end

	assign phaseCount = countPhases(activePhases);

	// Fixed-zone select register, written by the host
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fixedZoneSelect <= `PZC_FZ_RESET;
		end else if (regWrite && regAddr == `PZC_REG_FIXED_ZONE) begin
			fixedZoneSelect <= {1'b0, regWriteData[6:0]};
		end
	end

	// Shed thresholds: strap at latch time, host write overrides
	generate
		for (genvar t = 0; t < 4; t++) begin : g_thresh
			pzc_byte_t strapValue;
			pzc_byte_t regOffset;
			always_comb begin
				strapValue = shedThresholdStrap1;
				unique case (t)
					0: strapValue = shedThresholdStrap1;
					1: strapValue = shedThresholdStrap2;
					2: strapValue = shedThresholdStrap3;
					default: strapValue = shedThresholdStrap4;
				endcase
				regOffset = `PZC_REG_THRESH1 + 8'(t);
			end
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					thresh[t] <= `PZC_THRESH_OFF;
				end else if (regWrite && regAddr == regOffset) begin
					thresh[t] <= regWriteData;
				end else if (strapDone && !strapsLatched) begin
					thresh[t] <= strapValue;
				end
			end
		end
	endgenerate

	// Load-line percentage: strap at latch time, host write overrides
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			loadlineReg <= `PZC_LL_FULL;
		end else if (regWrite && regAddr == `PZC_REG_LOADLINE) begin
			loadlineReg <= regWriteData;
		end else if (strapDone && !strapsLatched) begin
			loadlineReg <= loadlineAddressStrap[0] ? `PZC_LL_NONE
				: `PZC_LL_FULL;
		end
	end

	assign loadlinePercent = loadlineReg;

	// Enable edge, held power-saving level and regulation tracking
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			enablePrev    <= 1'b0;
			psiHeld       <= PSI_HIGH;
			regulatedSeen <= 1'b0;
		end else begin
			enablePrev <= enableSync;
			if (enableRise) begin
				psiHeld <= psiLive;
			end
			if (!enableSync) begin
				regulatedSeen <= 1'b0;
			end else if (regulatedSync) begin
				regulatedSeen <= 1'b1;
			end
		end
	end

	assign enableRise = enableSync && !enablePrev;
	// Level caught at the enable edge applies at once, not a stale one
	assign psiUsed    = (regulatedSeen || enableRise) ? psiLive
		: psiHeld;

	// Once regulation is seen and the input has left low while enabled, low means first setting
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lowUseFirst <= 1'b0;
		end else if (!enableSync) begin
			lowUseFirst <= 1'b0;
		end else if (regulatedSeen && psiLive != PSI_LOW) begin
			lowUseFirst <= 1'b1;
		end
	end

	// Zone control mode
	always_comb begin
		next_mode = MODE_OFF;
		if (enableSync && strapsLatched) begin
			if (psiUsed == PSI_HIGH) begin
				next_mode = MODE_FULL;
			end else if (psiUsed == PSI_LOW) begin
				next_mode = MODE_FIXED;
			end else if (regulatedSeen) begin
				next_mode = MODE_SHED;
			end else begin
				next_mode = MODE_START;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode <= MODE_OFF;
		end else begin
			mode <= next_mode;
		end
	end

	// Current sample divider, one tick per period
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sampleCount <= '0;
		end else if (mode != MODE_SHED || sampleTick) begin
			sampleCount <= '0;
		end else begin
			sampleCount <= sampleCount + 11'd1;
		end
	end

	assign sampleTick = (sampleCount == 11'(SAMPLE_CYCLES - 1));

	// Compare current with thresholds; a full-scale one never trips
	always_comb begin
		if (totalCurrentLevel > thresh[3] && thresh[3] != `PZC_THRESH_OFF) begin
			next_shedZone = 3'd0;
		end else if (totalCurrentLevel > thresh[2]
			&& thresh[2] != `PZC_THRESH_OFF) begin
			next_shedZone = 3'd1;
		end else if (totalCurrentLevel > thresh[1]
			&& thresh[1] != `PZC_THRESH_OFF) begin
			next_shedZone = 3'd2;
		end else if (totalCurrentLevel > thresh[0]
			&& thresh[0] != `PZC_THRESH_OFF) begin
			next_shedZone = 3'd3;
		end else begin
			next_shedZone = 3'd4;
		end
	end

	// Shed zone updates only on a sample tick in shed mode; held at zone 0 outside shed mode
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shedZone <= 3'd0;
		end else if (mode != MODE_SHED) begin
			shedZone <= 3'd0;
		end else if (sampleTick) begin
			shedZone <= next_shedZone;
		end
	end

	// Fixed zone source: strap or register field, second then first
	always_comb begin
		if (lowUseFirst) begin
			fixedRaw = fixedZoneSelect[`PZC_FZ_SEC_EN_BIT]
				? clampZone(fixedZoneSelect[2:0]) : strapFirst;
		end else begin
			fixedRaw = fixedZoneSelect[`PZC_FZ_SEC_EN_BIT]
				? clampZone(fixedZoneSelect[5:3]) : strapSecond;
		end
	end

	// Zone before collapse, by mode
	always_comb begin
		rawZone = 3'd0;
		unique case (mode)
			MODE_FIXED: rawZone = fixedRaw;
			MODE_SHED:  rawZone = shedZone;
			MODE_FULL:  rawZone = 3'd0;
			MODE_START: rawZone = 3'd0;
			MODE_OFF:   rawZone = 3'd0;
		endcase
	end

	// Collapse per configuration and pick running outputs
	pzc_zone_map u_zone_map (
		.phaseCount (phaseCount),
		.rawZone    (rawZone),
		.zone       (mappedZone),
		.zoneMask   (zoneMask)
	);

	// Registered drive, zone and conduction outputs
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phaseDriveOut           <= 8'h00;
			powerZone               <= 3'd0;
			continuousConduction    <= 1'b0;
			discontinuousConduction <= 1'b0;
		end else if (mode == MODE_OFF) begin
			phaseDriveOut           <= 8'h00;
			powerZone               <= 3'd0;
			continuousConduction    <= 1'b0;
			discontinuousConduction <= 1'b0;
		end else begin
			phaseDriveOut <= zoneMask & activePhases;
			powerZone     <= mappedZone;
			continuousConduction    <= (mappedZone != 3'd4);
			discontinuousConduction <= (mappedZone == 3'd4);
		end
	end

	// Ramp-supply lockout only counts while enabled
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			undervoltageLockout <= 1'b0;
		end else begin
			undervoltageLockout <= enableSync && rampLowSync;
		end
	end

	// Read data, one cycle after the address; unmapped reads zero
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			regReadData <= 8'h00;
		end else begin
			unique case (regAddr)
				`PZC_REG_FIXED_ZONE: regReadData <= fixedZoneSelect;
				`PZC_REG_THRESH1:    regReadData <= thresh[0];
				`PZC_REG_THRESH2:    regReadData <= thresh[1];
				`PZC_REG_THRESH3:    regReadData <= thresh[2];
				`PZC_REG_THRESH4:    regReadData <= thresh[3];
				`PZC_REG_LOADLINE:   regReadData <= loadlineReg;
				`PZC_REG_PHASE_STAT: regReadData <= activePhases;
				`PZC_REG_ZONE_STAT:  regReadData <= {mode, powerZone};
				default:             regReadData <= 8'h00;
			endcase
		end
	end

endmodule

// [src/pzc_cfg.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef PZC_CFG_SVH
`define PZC_CFG_SVH

// Register offsets on the register side of the serial slave
`define PZC_REG_FIXED_ZONE  8'h36
`define PZC_REG_THRESH1     8'h37
`define PZC_REG_THRESH2     8'h38
`define PZC_REG_THRESH3     8'h39
`define PZC_REG_THRESH4     8'h3A
`define PZC_REG_LOADLINE    8'h3B
`define PZC_REG_PHASE_STAT  8'h3C
`define PZC_REG_ZONE_STAT   8'h3D

// Fixed-zone register fields
`define PZC_FZ_FIRST_LSB    0
`define PZC_FZ_SECOND_LSB   3
`define PZC_FZ_SEC_EN_BIT   6
`define PZC_FZ_RESET        8'h00

// Threshold code that marks a disabled shed threshold
`define PZC_THRESH_OFF      8'hFF

// Load-line percentages and slave addresses
`define PZC_LL_FULL         8'h64
`define PZC_LL_NONE         8'h00
`define PZC_ADDR_PAIR0      8'h20
`define PZC_ADDR_PAIR1      8'h30
`define PZC_ADDR_PAIR2      8'h40
`define PZC_ADDR_PAIR3      8'h50

// Phase count and zone limits
`define PZC_PHASES          8
`define PZC_ZONE_MAX        3'h4

// Current sampling period: 10 us at 125 MHz
`define PZC_SAMPLE_US       10
`define PZC_CLOCK_MHZ       125
`define PZC_SAMPLE_CYCLES   (`PZC_SAMPLE_US * `PZC_CLOCK_MHZ)

`endif

// [src/pzc_pkg.sv]
// Types shared by the phase and zone control block
package pzc_pkg;

	typedef logic [2:0] pzc_zone_t;
	typedef logic [7:0] pzc_byte_t;

	// Zone control mode, one-hot
	typedef enum logic [4:0] {
		MODE_OFF   = 5'b00001,
		MODE_START = 5'b00010,
		MODE_FULL  = 5'b00100,
		MODE_SHED  = 5'b01000,
		MODE_FIXED = 5'b10000
	} pzc_mode_e;

endpackage

// [src/pzc_zone_map.sv]
// Zone collapse per phase count and phase enable mask per zone
`timescale 1ns/1ps
module pzc_zone_map (
	// Configuration
	input  wire logic [3:0]         phaseCount,
	input  wire pzc_pkg::pzc_zone_t rawZone,
	// Result
	output pzc_pkg::pzc_zone_t      zone,
	output pzc_pkg::pzc_byte_t      zoneMask
);
	import pzc_pkg::*;

	// Zones a configuration lacks fall back to zone 0
	always_comb begin
		zone = rawZone;
		unique case (phaseCount)
			4'd8: zone = rawZone;
			4'd6,
			4'd4: if (rawZone == 3'd1) zone = 3'd0;
			4'd1: if (rawZone != 3'd4) zone = 3'd0;
			default: if (rawZone == 3'd1 || rawZone == 3'd2) zone = 3'd0;
		endcase
	end

	// Outputs left running in each zone
	always_comb begin
		zoneMask = 8'h01;
		unique case (zone)
			3'd0: zoneMask = 8'hFF;
			3'd1: zoneMask = 8'h55;
			3'd2: begin
				if (phaseCount == 4'd6) begin
					zoneMask = 8'h15;
				end else if (phaseCount == 4'd4) begin
					zoneMask = 8'h05;
				end else begin
					zoneMask = 8'h11;
				end
			end
			default: zoneMask = 8'h01;
		endcase
	end

endmodule

// [verification/pzc_host_model.sv]
// Processor side model that drives the three-level power-saving input
`timescale 1ns/1ps
module pzc_host_model (
	// Clock and requested level: 0 low, 1 middle, 2 high
	input  wire logic       clock,
	input  wire logic [1:0] level,
	// Comparator outputs seen by the block
	output logic            powerSavingHigh,
	output logic            powerSavingLow
);
	// Level changes launch just after an edge, like a real pin
	always_ff @(posedge clock) begin
		powerSavingHigh <= (level == 2'h2);
		powerSavingLow  <= (level == 2'h0);
	end
endmodule

// [verification/pzc_props.sv]
// Concurrent checks on the phase and zone control ports
`timescale 1ns/1ps
module pzc_props (
	// Clock and reset
	input wire logic               clock,
	input wire logic               resetn,
	// Watched ports
	input wire logic               enable,
	input wire logic               regWrite,
	input wire pzc_pkg::pzc_byte_t regAddr,
	input wire pzc_pkg::pzc_byte_t regWriteData,
	input wire pzc_pkg::pzc_byte_t regReadData,
	input wire pzc_pkg::pzc_byte_t phaseDriveOut,
	input wire pzc_pkg::pzc_byte_t activePhases,
	input wire pzc_pkg::pzc_zone_t powerZone,
	input wire logic               continuousConduction,
	input wire logic               discontinuousConduction,
	input wire logic               undervoltageLockout,
	input wire logic               strapsLatched
);
	import pzc_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// Write to threshold one followed by a read of it
	sequence wr37_s;
		regWrite && regAddr == 8'h37 ##1 regAddr == 8'h37;
	endsequence
	latch_once_a: assert property (
		strapsLatched |=> strapsLatched && $stable(activePhases))
		else $error("strap results changed after latch");
	contig_mask_a: assert property (
		((activePhases + 8'h01) & activePhases) == 8'h00)
		else $error("enabled phases not contiguous");
	drive_sub_a: assert property (
		(phaseDriveOut & ~activePhases) == 8'h00)
		else $error("disabled phase driven");
	dcm_zone_a: assert property (
		discontinuousConduction |-> powerZone == 3'h4
		&& !continuousConduction)
		else $error("discontinuous outside zone four");
	ccm_zone_a: assert property (
		continuousConduction |-> powerZone < 3'h4)
		else $error("continuous in zone four");
	low_zone_a: assert property (
		(continuousConduction || discontinuousConduction)
		&& powerZone >= 3'h3
		|-> phaseDriveOut == (activePhases & 8'h01))
		else $error("low zone drives more than phase one");
	lockout_off_a: assert property (
		!enable [*4] |-> !undervoltageLockout)
		else $error("lockout while disabled");
	drive_off_a: assert property (
		!enable [*5] |-> phaseDriveOut == 8'h00 && !continuousConduction)
		else $error("outputs run while disabled");
	status_rd_a: assert property (
		regAddr == 8'h3C |=> regReadData == $past(activePhases))
		else $error("phase status read wrong");
	rd_back_a: assert property (
		wr37_s |=> regReadData == $past(regWriteData, 2))
		else $error("threshold readback wrong");
endmodule

// [verification/tb_top.sv]
// Self-checking bench for phase and zone control
`timescale 1ns/1ps
module tb_top;
	import pzc_pkg::*;
	logic clock, resetn, enable, outputRegulated, rampSupplyLow, strapDone;
	logic [1:0] level;
	logic powerSavingHigh, powerSavingLow, regWrite, continuous_conduction, discontinuous_conduction, undervoltage_lockout, latched;
	logic [7:0] sense, regAddr, regWriteData, regReadData, cur, drive, act;
	logic [7:0] llp, addr, t1, t2, t3, t4;
	logic [2:0] z1, z2, llIdx, powerZone;
	logic [7:0] th [1:4];
	logic [31:0] st = 32'd88907;
	int fail_count = 0, total_checks = 0, n, i;
	pzc_host_model host (.clock, .level, .powerSavingHigh, .powerSavingLow);
	phase_zone_config_control #(.SAMPLE_CYCLES(8)) dut (.clock, .resetn,
		.enable, .powerSavingHigh, .powerSavingLow, .outputRegulated,
		.rampSupplyLow, .phaseSensePositive(sense), .strapDone,
		.fixedZoneStrapFirst(z1), .fixedZoneStrapSecond(z2),
		.shedThresholdStrap1(t1), .shedThresholdStrap2(t2),
		.shedThresholdStrap3(t3), .shedThresholdStrap4(t4),
		.loadlineAddressStrap(llIdx), .totalCurrentLevel(cur), .regWrite,
		.regAddr, .regWriteData, .regReadData, .phaseDriveOut(drive),
		.activePhases(act), .powerZone, .continuousConduction(continuous_conduction),
		.discontinuousConduction(discontinuous_conduction), .undervoltageLockout(undervoltage_lockout),
		.loadlinePercent(llp), .slaveAddress(addr), .strapsLatched(latched));
	// Clock at 8 ns
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	// Repeatable pseudo-random source
	function automatic logic [31:0] rnd();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction
	function automatic logic [7:0] msk(int k);
		return 8'hFF >> (8 - k);
	endfunction
	// Zone collapse for phase counts that lack a zone
	function automatic logic [2:0] col(int k, logic [2:0] z);
		if (z == 3'h1) return (k == 8) ? 3'h1 : 3'h0;
		if (z == 3'h2) return (k == 8 || k == 6 || k == 4) ? 3'h2 : 3'h0;
		if (z == 3'h3) return (k >= 2) ? 3'h3 : 3'h0;
		return z;
	endfunction
	function automatic logic [7:0] drv(int k, logic [2:0] z);
		if (z == 3'h0) return msk(k);
		if (z == 3'h1) return 8'h55;
		if (z == 3'h2) return (k == 8) ? 8'h11 : ((k == 6) ? 8'h15 : 8'h05);
		return 8'h01;
	endfunction
	// Shed zone from current against the threshold table
	function automatic logic [2:0] shed(logic [7:0] c);
		for (int j = 4; j >= 1; j--)
			if (th[j] != 8'hFF && c > th[j]) return 3'(4 - j);
		return 3'h4;
	endfunction
	task automatic cyc(int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		cyc(1);
		regWrite = 1;
		regAddr = a;
		regWriteData = d;
		cyc(1);
		regWrite = 0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
		cyc(1);
		regAddr = a;
		cyc(1);
		chk(nm, regReadData, e);
	endtask
	task automatic zone_is(logic [2:0] z, int k);
		chk("zone", {5'h0, powerZone}, {5'h0, z});
		chk("drive", drive, drv(k, z));
		chk("dcm", {7'h0, discontinuous_conduction}, {7'h0, z == 3'h4});
		chk("ccm", {7'h0, continuous_conduction}, {7'h0, z != 3'h4});
	endtask
	// Reset, present straps and latch them once
	task automatic boot(int k, logic [1:0] lv);
		resetn = 0;
		enable = 0;
		outputRegulated = 0;
		level = lv;
		llIdx = 3'(k - 1);
		sense = (k == 8) ? 8'h00 : ((rnd() | (8'h01 << k)) & ~msk(k));
		{t1, t2, t3, t4} = rnd();
		cyc(8);
		resetn = 1;
		// Pin synchronisers need two edges before the straps are seen
		cyc(2);
		strapDone = 1;
		cyc(1);
		strapDone = 0;
		cyc(2);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Watchdog
	initial begin
		#200000;
		fail_count++;
		test_done();
	end
	initial begin
		{resetn, enable, outputRegulated, rampSupplyLow, strapDone} = 0;
		{regWrite, regAddr, regWriteData, cur, sense, z1, z2, llIdx} = 0;
		{level, t1, t2, t3, t4} = 0;
		for (n = 1; n <= 8; n++) begin
			z1 = 3'(rnd() % 5);
			z2 = 3'(rnd() % 5);
			boot(n, 2'h0);
			chk("phases", act, msk(n));
			chk("latched", {7'h0, latched}, 8'h01);
			rd(8'h3C, msk(n), "status");
			chk("loadline", llp, (n % 2) ? 8'h64 : 8'h00);
			chk("address", addr, 8'(32'h20 + 16 * ((n - 1) / 2)));
			enable = 1;
			cyc(10);
			zone_is(col(n, z2), n);
			level = 2'h2;
			cyc(10);
			zone_is(col(n, z2), n);
			outputRegulated = 1;
			cyc(10);
			zone_is(3'h0, n);
			level = 2'h0;
			cyc(10);
			zone_is(col(n, z1), n);
			$display("test phase count %0d done", n);
		end
		boot(8, 2'h1);
		enable = 1;
		cyc(10);
		zone_is(3'h0, 8);
		th = '{8'h20, 8'h40, 8'h60, 8'h80};
		for (i = 4; i >= 1; i--) wr(8'(8'h36 + i), th[i]);
		rd(8'h37, 8'h20, "threshold");
		rd(8'h50, 8'h00, "unmapped");
		wr(8'h3C, 8'h00);
		rd(8'h3C, 8'hFF, "status");
		wr(8'h3B, 8'h33);
		chk("loadline", llp, 8'h33);
		outputRegulated = 1;
		for (i = 0; i < 20; i++) begin
			if (i == 10) begin
				th[3] = 8'hFF;
				wr(8'h39, 8'hFF);
			end
			cur = (i < 4) ? 8'(32'h81802000 >> (8 * i)) : 8'(rnd());
			cyc(30);
			zone_is(shed(cur), 8);
		end
		$display("test shedding done");
		wr(8'h36, 8'h59);
		rd(8'h36, 8'h59, "fixed zone");
		level = 2'h0;
		cyc(10);
		zone_is(3'h1, 8);
		rd(8'h3D, {MODE_FIXED, 3'h1}, "zone status");
		rampSupplyLow = 1;
		cyc(8);
		chk("lockout", {7'h0, undervoltage_lockout}, 8'h01);
		enable = 0;
		cyc(8);
		chk("lockout", {7'h0, undervoltage_lockout}, 8'h00);
		// Fresh enable with input low: register second field applies
		outputRegulated = 0;
		enable = 1;
		cyc(10);
		zone_is(3'h3, 8);
		chk("lockout", {7'h0, undervoltage_lockout}, 8'h01);
		$display("test registers done");
		test_done();
	end
endmodule
bind phase_zone_config_control pzc_props u_props (.clock, .resetn, .enable,
	.regWrite, .regAddr, .regWriteData, .regReadData, .phaseDriveOut,
	.activePhases, .powerZone, .continuousConduction,
	.discontinuousConduction, .undervoltageLockout, .strapsLatched);
